// ---- rtl/mmac_consts.svh ----
// Address map bounds, field positions and timing counts of the access control block
`ifndef MMAC_CONSTS_SVH
`define MMAC_CONSTS_SVH
`define MMAC_PERIPH_HI 16'h0FFF
`define MMAC_BOOT_LO 16'h1000
`define MMAC_BOOT_HI 16'h17FF
`define MMAC_INFO_LO 16'h1800
`define MMAC_INFO_HI 16'h19FF
`define MMAC_DESC_LO 16'h1A00
`define MMAC_DESC_HI 16'h1AFF
`define MMAC_RAM0_LO 16'h1C00
`define MMAC_RAM0_HI 16'h23FF
`define MMAC_RAM1_LO 16'h2400
`define MMAC_RAM1_HI 16'h2BFF
`define MMAC_MAIN_LO_32K 16'h8000
`define MMAC_MAIN_LO_16K 16'hC000
`define MMAC_MAIN_LO_8K 16'hE000
`define MMAC_VEC_LO 16'hFF80
`define MMAC_VEC_RESET 16'hFFFE
`define MMAC_MAIN_SEG_MSB 15
`define MMAC_MAIN_SEG_LSB 9
`define MMAC_INFO_SEG_MSB 8
`define MMAC_INFO_SEG_LSB 7
`define MMAC_INFO_A_IDX 2'h3
`define MMAC_INFO_ALL 4'hF
`define MMAC_INFO_NO_A 4'h7
`define MMAC_ENTRY_EDGES 2'h2
`define MMAC_TW_ANS 4'hF
`define MMAC_TW_DIV 8'h10
`define MMAC_ENTRY_LAST 3'h7
`define MMAC_ENTRY_PULSE_END 3'h5
`define MMAC_ENTRY_RELEASE 3'h6
`endif

// ---- rtl/mmac_device.sv ----
// Device end: address decode, access checks, flash commands and pin duties
// Behaviour
// - Fetch from peripheral space forces system reset
// - Unmapped access sets vacant flag and interrupt
// - Source enable masks NMI; global enable ignored
// - Vector table at top; reserved words are flash
// - Main flash 512-byte segments, variant lower bound
// - Four 128-byte info segments, A highest
// - Main mass erase and single segment erase
// - Info segments erased singly or with main
// - Separate lock protects info segment A
// - CPU programs byte, word and long-word
// - Programming from four-wire, two-wire, CPU or unlocked boot loader
// - Boot-loader flash as four 512-byte blocks
// - Two 128-byte descriptor areas above info
// - Boot-loader access refused until password matches
// - Host drives entry sequence on two pins
// - Test pin switches shared pins to test port
// - Two-wire port: host clock, bidirectional data
// - One handler word per vector, reset at top
`timescale 1ns/1ns
`include "mmac_consts.svh"
module mmac_device import mmac_pkg::*; #(
  parameter int RAM_KB = 4,
  parameter int MAIN_KB = 32,
  parameter logic [31:0] BOOT_PASSWORD = 32'hC3A5_5A3C
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to host
  mmac_if.dev lnk,
  // Protection and interrupt control
  input wire logic lock_a,
  input wire logic vacant_ie,
  input wire logic vacant_clr,
  // Status
  output logic vacant_access_flag,
  output logic sys_nmi,
  output logic sys_reset,
  output logic test_port_mode,
  output logic boot_loader_active,
  output logic boot_loader_unlocked,
  // Flash erase command
  output logic erase_go,
  output logic erase_main_all,
  output logic erase_main_seg_en,
  output logic [6:0] erase_seg,
  output logic [3:0] erase_info_mask,
  // Flash program command and reset vector address
  output logic prog_go,
  output mmac_width_e prog_width,
  output logic [15:0] prog_addr,
  output logic [31:0] prog_data,
  output logic [15:0] reset_vector_addr
);
  mmac_region_e region;
  logic [6:0] seg;
  logic take, is_flash, info_a, lock_hit, boot_block, bad_erase, vacant_hit, periph_fetch, refuse;
  logic [3:0] info_onehot, next_info_mask;
  logic dat_s1, dat_s2, tck_s1, tck_s2, tck_q;
  logic [1:0] edge_cnt;
  logic [3:0] tw_cnt;
  logic tw_ok;

  mmac_region_decode #(.RAM_KB(RAM_KB), .MAIN_KB(MAIN_KB)) u_dec (
    .addr(lnk.addr),
    .region(region),
    .seg(seg)
  );

  // Request is taken once; ack blocks a retake of the same request
  assign take = lnk.req && !lnk.ack;
  assign is_flash = region == REG_MAIN || region == REG_VECTOR || region == REG_INFO || region == REG_BOOT;
  assign info_a = region == REG_INFO && lnk.addr[`MMAC_INFO_SEG_MSB:`MMAC_INFO_SEG_LSB] == `MMAC_INFO_A_IDX;
  assign info_onehot = 4'h1 << lnk.addr[`MMAC_INFO_SEG_MSB:`MMAC_INFO_SEG_LSB];
  assign lock_hit = lock_a && info_a && (lnk.kind == K_WRITE || (lnk.kind == K_ERASE && lnk.emode == E_INFO_SEG));
  assign boot_block = lnk.src == SRC_BOOT && !boot_loader_unlocked && lnk.kind != K_PASS;
  assign vacant_hit = region == REG_VACANT && lnk.kind != K_PASS && !(lnk.kind == K_ERASE
    && (lnk.emode == E_MAIN_ALL || lnk.emode == E_ALL));
  assign periph_fetch = region == REG_PERIPH && lnk.kind == K_FETCH;
  // Single-segment erase must point into the matching flash area
  always_comb begin
    bad_erase = 1'b0;
    if (lnk.kind == K_ERASE) begin
      case (lnk.emode)
        E_SEG: bad_erase = !(region == REG_MAIN || region == REG_VECTOR);
        E_INFO_SEG: bad_erase = region != REG_INFO;
        default: bad_erase = 1'b0;
      endcase
    end
  end
  assign refuse = lock_hit || boot_block || vacant_hit || periph_fetch || bad_erase
    || (lnk.kind == K_PASS && lnk.wdata != BOOT_PASSWORD);

  // Answer to the host, one cycle after the take
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.ack <= 1'b0;
      lnk.refused <= 1'b0;
      lnk.region <= REG_VACANT;
    end else begin
      lnk.ack <= take;
      if (take) begin
        lnk.refused <= refuse;
        lnk.region <= region;
      end
    end
  end

  // Peripheral fetch never executes; a reset pulse replaces it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sys_reset <= 1'b0;
    else sys_reset <= take && periph_fetch && !boot_block;
  end

  // Sticky vacant flag; a new hit wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) vacant_access_flag <= 1'b0;
    else vacant_access_flag <= (take && vacant_hit && !boot_block) || (vacant_access_flag && !vacant_clr);
  end
  // Only the source enable gates this interrupt; there is no global mask input on purpose
  assign sys_nmi = vacant_access_flag && vacant_ie;

  // Erase command decode
  always_comb begin
    next_info_mask = 4'h0;
    case (lnk.emode)
      E_INFO_SEG: next_info_mask = info_onehot;
      E_ALL: next_info_mask = lock_a ? `MMAC_INFO_NO_A : `MMAC_INFO_ALL;
      default: next_info_mask = 4'h0;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_go <= 1'b0;
      erase_main_all <= 1'b0;
      erase_main_seg_en <= 1'b0;
      erase_seg <= 7'h00;
      erase_info_mask <= 4'h0;
    end else begin
      erase_go <= take && lnk.kind == K_ERASE && !refuse;
      if (take && lnk.kind == K_ERASE && !refuse) begin
        erase_main_all <= lnk.emode == E_MAIN_ALL || lnk.emode == E_ALL;
        erase_main_seg_en <= lnk.emode == E_SEG;
        erase_seg <= seg;
        erase_info_mask <= next_info_mask;
      end
    end
  end

  // Program command; any of the four sources may write flash, the boot loader once unlocked
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_go <= 1'b0;
      prog_width <= W_BYTE;
      prog_addr <= 16'h0000;
      prog_data <= 32'h0000_0000;
    end else begin
      prog_go <= take && lnk.kind == K_WRITE && is_flash && !refuse;
      if (take && lnk.kind == K_WRITE && is_flash && !refuse) begin
        // Long words only from the CPU; debug ports write words at most
        prog_width <= (lnk.src != SRC_CPU && lnk.width == W_LONG) ? W_WORD : lnk.width;
        prog_addr <= lnk.addr;
        prog_data <= lnk.wdata;
      end
    end
  end
  assign reset_vector_addr = `MMAC_VEC_RESET;

  // Pins come from the host side: two flops before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_q <= 1'b0;
    end else begin
      dat_s1 <= lnk.reset_nmi_twowire_data_pin;
      dat_s2 <= dat_s1;
      tck_s1 <= lnk.test_twowire_clock_pin;
      tck_s2 <= tck_s1;
      tck_q <= tck_s2;
    end
  end

  // Entry: clock edges while data held low, then data rises with clock high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= 2'h0;
      boot_loader_active <= 1'b0;
    end else if (!dat_s2) begin
      if (tck_s2 && !tck_q && edge_cnt != `MMAC_ENTRY_EDGES) edge_cnt <= edge_cnt + 2'h1;
    end else begin
      if (edge_cnt == `MMAC_ENTRY_EDGES && tck_s2) boot_loader_active <= 1'b1;
      edge_cnt <= 2'h0;
    end
  end

  // Password unlocks boot-loader access until the next reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) boot_loader_unlocked <= 1'b0;
    else if (take && lnk.kind == K_PASS && lnk.wdata == BOOT_PASSWORD) boot_loader_unlocked <= 1'b1;
  end

  // Shared pins serve the test port while the test pin is high and the boot loader is not active
  assign test_port_mode = tck_s2 && !boot_loader_active;

  // Two-wire answer: device drives the status bit back while clock is high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tw_cnt <= 4'h0;
      tw_ok <= 1'b0;
      lnk.dev_dat_o <= 1'b1;
      lnk.dev_dat_oe <= 1'b0;
    end else begin
      if (take && lnk.src == SRC_TWO) begin
        tw_cnt <= `MMAC_TW_ANS;
        tw_ok <= !refuse;
      end else if (tw_cnt != 4'h0) begin
        tw_cnt <= tw_cnt - 4'h1;
      end
      lnk.dev_dat_o <= tw_ok;
      lnk.dev_dat_oe <= tw_cnt != 4'h0 && tck_s2;
    end
  end
endmodule : mmac_device

// ---- rtl/mmac_host.sv ----
// Host end: issues accesses, drives the boot-loader entry sequence and the test clock
`timescale 1ns/1ns
`include "mmac_consts.svh"
module mmac_host import mmac_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link to device
  mmac_if.host lnk,
  // User request
  input wire logic u_req,
  input wire mmac_kind_e u_kind,
  input wire mmac_width_e u_width,
  input wire mmac_src_e u_src,
  input wire mmac_erase_e u_emode,
  input wire logic [15:0] u_addr,
  input wire logic [31:0] u_wdata,
  input wire logic u_boot_enter,
  input wire logic u_test_en,
  // User answer
  output logic u_busy,
  output logic u_ack,
  output logic u_refused,
  output mmac_region_e u_region,
  output logic u_tw_bit
);
  mmac_hstate_e state;
  logic [7:0] div_cnt;
  logic div_en;
  logic [2:0] step;
  logic dat_s1, dat_s2;

  assign u_busy = state != H_IDLE;
  // Half-period tick for the entry sequence clock
  assign div_en = div_cnt == `MMAC_TW_DIV;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) div_cnt <= 8'h00;
    else if (state != H_ENTRY || div_en) div_cnt <= 8'h00;
    else div_cnt <= div_cnt + 8'h01;
  end

  // Control sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= H_IDLE;
      step <= 3'h0;
    end else begin
      case (state)
        H_IDLE: begin
          step <= 3'h0;
          if (u_boot_enter) state <= H_ENTRY;
          else if (u_req) state <= H_REQ;
        end
        H_REQ: if (lnk.ack) state <= H_IDLE;
        H_ENTRY: if (div_en) begin
          if (step == `MMAC_ENTRY_LAST) state <= H_IDLE;
          else step <= step + 3'h1;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Request fields held until the device answers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.req <= 1'b0;
      lnk.kind <= K_READ;
      lnk.width <= W_BYTE;
      lnk.src <= SRC_CPU;
      lnk.emode <= E_SEG;
      lnk.addr <= 16'h0000;
      lnk.wdata <= 32'h0000_0000;
    end else if (state == H_IDLE && u_req && !u_boot_enter) begin
      lnk.req <= 1'b1;
      lnk.kind <= u_kind;
      lnk.width <= u_width;
      lnk.src <= u_src;
      lnk.emode <= u_emode;
      lnk.addr <= u_addr;
      lnk.wdata <= u_wdata;
    end else if (lnk.ack) begin
      lnk.req <= 1'b0;
    end
  end

  // Answer capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      u_ack <= 1'b0;
      u_refused <= 1'b0;
      u_region <= REG_VACANT;
    end else begin
      u_ack <= state == H_REQ && lnk.ack;
      if (state == H_REQ && lnk.ack) begin
        u_refused <= lnk.refused;
        u_region <= lnk.region;
      end
    end
  end

  // Entry: data low, three clock pulses, data released high with clock high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.host_dat_o <= 1'b1;
      lnk.host_dat_oe <= 1'b0;
      lnk.test_twowire_clock_pin <= 1'b0;
    end else if (state == H_ENTRY) begin
      lnk.host_dat_oe <= 1'b1;
      lnk.host_dat_o <= step >= `MMAC_ENTRY_RELEASE;
      lnk.test_twowire_clock_pin <= (step[0] && step <= `MMAC_ENTRY_PULSE_END) || step == `MMAC_ENTRY_RELEASE;
    end else begin
      lnk.host_dat_oe <= 1'b0;
      lnk.host_dat_o <= 1'b1;
      lnk.test_twowire_clock_pin <= u_test_en;
    end
  end

  // Returned two-wire bit, synchronised before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
      u_tw_bit <= 1'b1;
    end else begin
      dat_s1 <= lnk.reset_nmi_twowire_data_pin;
      dat_s2 <= dat_s1;
      u_tw_bit <= dat_s2;
    end
  end
endmodule : mmac_host

// ---- rtl/mmac_if.sv ----
// Link between the access control device end and the host end
`timescale 1ns/1ns
interface mmac_if;
  import mmac_pkg::*;
  logic req;
  mmac_kind_e kind;
  mmac_width_e width;
  mmac_src_e src;
  mmac_erase_e emode;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic refused;
  mmac_region_e region;
  // Shared reset / two-wire data pin, pulled high when nobody drives it
  logic dev_dat_o, dev_dat_oe, host_dat_o, host_dat_oe;
  logic reset_nmi_twowire_data_pin;
  logic test_twowire_clock_pin;
  assign reset_nmi_twowire_data_pin = dev_dat_oe ? dev_dat_o : (host_dat_oe ? host_dat_o : 1'b1);
  modport dev(input req, kind, width, src, emode, addr, wdata, reset_nmi_twowire_data_pin,
    test_twowire_clock_pin, output ack, refused, region, dev_dat_o, dev_dat_oe);
  modport host(output req, kind, width, src, emode, addr, wdata, host_dat_o, host_dat_oe,
    test_twowire_clock_pin, input ack, refused, region, reset_nmi_twowire_data_pin);
endinterface : mmac_if

// ---- rtl/mmac_pkg.sv ----
// Types shared by both ends of the memory map access control link
package mmac_pkg;
  typedef enum logic [8:0] {
    REG_PERIPH = 9'h001, REG_BOOT = 9'h002, REG_INFO = 9'h004, REG_DESC = 9'h008, REG_RAM0 = 9'h010,
    REG_RAM1 = 9'h020, REG_MAIN = 9'h040, REG_VECTOR = 9'h080, REG_VACANT = 9'h100
  } mmac_region_e;
  typedef enum logic [2:0] {K_READ = 3'h0, K_WRITE = 3'h1, K_FETCH = 3'h2, K_ERASE = 3'h3, K_PASS = 3'h4} mmac_kind_e;
  typedef enum logic [1:0] {W_BYTE = 2'h0, W_WORD = 2'h1, W_LONG = 2'h2} mmac_width_e;
  typedef enum logic [1:0] {SRC_CPU = 2'h0, SRC_FOUR = 2'h1, SRC_TWO = 2'h2, SRC_BOOT = 2'h3} mmac_src_e;
  typedef enum logic [1:0] {E_SEG = 2'h0, E_MAIN_ALL = 2'h1, E_INFO_SEG = 2'h2, E_ALL = 2'h3} mmac_erase_e;
  typedef enum logic [2:0] {H_IDLE = 3'h1, H_REQ = 3'h2, H_ENTRY = 3'h4} mmac_hstate_e;
endpackage : mmac_pkg

// ---- rtl/mmac_region_decode.sv ----
// Address to region decoder with flash segment index
`timescale 1ns/1ns
`include "mmac_consts.svh"
module mmac_region_decode import mmac_pkg::*; #(
  parameter int RAM_KB = 4,
  parameter int MAIN_KB = 32
) (
  // Address in
  input wire logic [15:0] addr,
  // Decoded region and main segment
  output mmac_region_e region,
  output logic [6:0] seg
);
  logic [15:0] main_lo;
  // Lower main bound follows the fitted flash size
  always_comb begin
    case (MAIN_KB)
      16: main_lo = `MMAC_MAIN_LO_16K;
      8: main_lo = `MMAC_MAIN_LO_8K;
      default: main_lo = `MMAC_MAIN_LO_32K;
    endcase
  end
  // Priority chain: exactly one region per address
  always_comb begin
    if (addr <= `MMAC_PERIPH_HI) region = REG_PERIPH;
    else if (addr <= `MMAC_BOOT_HI) region = REG_BOOT;
    else if (addr <= `MMAC_INFO_HI) region = REG_INFO;
    else if (addr <= `MMAC_DESC_HI) region = REG_DESC;
    else if (addr >= `MMAC_RAM0_LO && addr <= `MMAC_RAM0_HI) region = REG_RAM0;
    else if (addr >= `MMAC_RAM1_LO && addr <= `MMAC_RAM1_HI && RAM_KB >= 4) region = REG_RAM1;
    else if (addr >= `MMAC_VEC_LO) region = REG_VECTOR;
    else if (addr >= main_lo) region = REG_MAIN;
    else region = REG_VACANT;
  end
  // Segment of 512 bytes; vector words share the top segment
  assign seg = addr[`MMAC_MAIN_SEG_MSB:`MMAC_MAIN_SEG_LSB];
endmodule : mmac_region_decode

// ---- tb/mmac_assertions.sv ----
// Concurrent checks on the link between the device end and the host end
`timescale 1ns/1ns
module mmac_assertions import mmac_pkg::*, mmac_tb_pkg::*; #(
  parameter int RAM_KB = 4,
  parameter int MAIN_KB = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic req,
  input wire mmac_kind_e kind,
  input wire mmac_src_e src,
  input wire mmac_erase_e emode,
  input wire logic [15:0] addr,
  input wire logic ack,
  input wire logic refused,
  input wire mmac_region_e region,
  input wire logic dev_dat_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Decode of the request address under check
  mmac_region_e exp_r;
  assign exp_r = exp_region(addr, RAM_KB, MAIN_KB);

  // Drive run since the last two-wire answer; a new two-wire request restarts the window
  logic [4:0] oe_run;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) oe_run <= 5'h00;
    else oe_run <= (dev_dat_oe && !(ack && src == SRC_TWO)) ? oe_run + 5'h01 : 5'h00;
  end

  a_ack_after_take: assert property (req && !ack |=> ack)
    else $error("No ack one cycle after a taken request");
  a_ack_single: assert property (ack |=> !ack)
    else $error("Ack longer than one cycle");
  a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(kind))
    else $error("Request changed before ack");
  a_region_decode: assert property (ack |-> region == exp_r)
    else $error("Region does not match address");
  a_region_onehot: assert property ($onehot(region))
    else $error("Region select not one-hot");
  a_periph_fetch: assert property (ack && kind == K_FETCH && addr <= 16'h0FFF |-> refused)
    else $error("Fetch from peripheral space accepted");
  a_vacant_refused: assert property (ack && kind != K_ERASE && kind != K_PASS && exp_r == REG_VACANT |-> refused)
    else $error("Vacant access accepted");
  a_mapped_read: assert property (ack && kind == K_READ && src == SRC_CPU && exp_r != REG_VACANT |-> !refused)
    else $error("Mapped processor read refused");
  a_seg_erase_out: assert property (ack && kind == K_ERASE && emode == E_SEG
    && !(exp_r inside {REG_MAIN, REG_VECTOR}) |-> refused)
    else $error("Segment erase outside main flash accepted");
  a_info_erase_out: assert property (ack && kind == K_ERASE && emode == E_INFO_SEG && exp_r != REG_INFO |-> refused)
    else $error("Info erase outside info flash accepted");
  a_dat_window: assert property (oe_run <= 5'h0F)
    else $error("Data pin driven over fifteen cycles");
endmodule : mmac_assertions

// ---- tb/mmac_tb_pkg.sv ----
// Expected address decode shared by the bench and the checker
package mmac_tb_pkg;
  import mmac_pkg::*;

  // Lowest region that matches wins, except vector over main; gaps fall through to vacant
  function automatic mmac_region_e exp_region(logic [15:0] a, int ram_kb, int main_kb);
    logic [15:0] lo;
    lo = (main_kb == 32) ? 16'h8000 : ((main_kb == 16) ? 16'hC000 : 16'hE000);
    if (a <= 16'h0FFF) return REG_PERIPH;
    if (a <= 16'h17FF) return REG_BOOT;
    if (a <= 16'h19FF) return REG_INFO;
    if (a <= 16'h1AFF) return REG_DESC;
    if (a >= 16'h1C00 && a <= 16'h23FF) return REG_RAM0;
    if (a >= 16'h2400 && a <= 16'h2BFF && ram_kb == 4) return REG_RAM1;
    if (a >= 16'hFF80) return REG_VECTOR;
    if (a >= lo) return REG_MAIN;
    return REG_VACANT;
  endfunction : exp_region
endpackage : mmac_tb_pkg

// ---- tb/tb_memory_map_access_control.sv ----
// Self-checking bench for the device and host ends joined by their link
`timescale 1ns/1ns
module tb_memory_map_access_control import mmac_pkg::*, mmac_tb_pkg::*;;
  localparam logic [31:0] PW = 32'hC3A5_5A3C; // Arbitrary password value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic lock_a = 1'b0;
  logic vacant_ie = 1'b0;
  logic vacant_clr = 1'b0;
  logic u_req = 1'b0;
  logic u_boot_enter = 1'b0;
  logic u_test_en = 1'b0;
  mmac_kind_e u_kind = K_READ;
  mmac_width_e u_width = W_WORD;
  mmac_src_e u_src = SRC_CPU;
  mmac_erase_e u_emode = E_SEG;
  logic [15:0] u_addr = 16'h0000;
  logic [31:0] u_wdata = 32'h0000_0000;
  logic vacant_access_flag, sys_nmi, sys_reset, test_port_mode, boot_loader_active, boot_loader_unlocked;
  logic erase_go, erase_main_all, erase_main_seg_en, prog_go, u_busy, u_ack, u_refused, u_tw_bit;
  logic [6:0] erase_seg;
  logic [3:0] erase_info_mask;
  mmac_width_e prog_width;
  logic [15:0] prog_addr, reset_vector_addr;
  logic [31:0] prog_data;
  mmac_region_e u_region;
  logic saw_rst, saw_er, saw_pg;
  int n_fail = 0;
  int total_checks = 0;
  logic [15:0] corner [19] = '{16'h0FFF, 16'h1000, 16'h0000, 16'h17FF, 16'h1800, 16'h19FF, 16'h1A00,
    16'h1AFF, 16'h1B00, 16'h1C00, 16'h23FF, 16'h2400, 16'h2BFF, 16'h2C00, 16'h7FFF, 16'h8000, 16'hFF7F,
    16'hFF80, 16'hFFFF};

  // Clock, 8 ns period
  always #4 core_clk = ~core_clk;

  mmac_if mmac_if_i ();
  mmac_device #(.RAM_KB(4), .MAIN_KB(32), .BOOT_PASSWORD(PW)) mmac_device_i (.core_clk, .rst_n,
    .lnk(mmac_if_i), .lock_a, .vacant_ie, .vacant_clr, .vacant_access_flag, .sys_nmi, .sys_reset,
    .test_port_mode, .boot_loader_active, .boot_loader_unlocked, .erase_go, .erase_main_all,
    .erase_main_seg_en, .erase_seg, .erase_info_mask, .prog_go, .prog_width, .prog_addr, .prog_data,
    .reset_vector_addr);
  mmac_host mmac_host_i (.core_clk, .rst_n, .lnk(mmac_if_i), .u_req, .u_kind, .u_width, .u_src, .u_emode,
    .u_addr, .u_wdata, .u_boot_enter, .u_test_en, .u_busy, .u_ack, .u_refused, .u_region, .u_tw_bit);
  mmac_assertions #(.RAM_KB(4), .MAIN_KB(32)) mmac_assertions_i (.core_clk, .rst_n, .req(mmac_if_i.req),
    .kind(mmac_if_i.kind), .src(mmac_if_i.src), .emode(mmac_if_i.emode), .addr(mmac_if_i.addr),
    .ack(mmac_if_i.ack), .refused(mmac_if_i.refused), .region(mmac_if_i.region),
    .dev_dat_oe(mmac_if_i.dev_dat_oe));

  // Pulses last one cycle, so latch them until the task has seen the answer
  always @(posedge core_clk) begin
    if (u_req) {saw_rst, saw_er, saw_pg} <= 3'h0;
    if (sys_reset) saw_rst <= 1'b1;
    if (erase_go) saw_er <= 1'b1;
    if (prog_go) saw_pg <= 1'b1;
  end

  task automatic chk_b(string nm, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  task automatic chk_v(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_v

  task automatic done(string nm);
    $display("Test %s ended, failures so far %0d", nm, n_fail);
  endtask : done

  // One access through the host; returns at the negedge that shows u_ack
  task automatic acc(mmac_kind_e k, mmac_src_e s, mmac_erase_e e, logic [15:0] a,
    mmac_width_e w = W_WORD, logic [31:0] d = 32'h0000_0000);
    int i;
    @(negedge core_clk);
    u_kind = k;
    u_src = s;
    u_emode = e;
    u_addr = a;
    u_width = w;
    u_wdata = d;
    u_req = 1'b1;
    @(negedge core_clk);
    u_req = 1'b0;
    for (i = 0; i < 20 && u_ack !== 1'b1; i++) @(negedge core_clk);
    chk_b("answer", 1'b1, u_ack);
  endtask : acc

  task automatic give_verdict;
    $display("Checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Whole run needs some 550 cycles; over thirty times that means a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    int i;
    mmac_kind_e k;
    mmac_region_e r;
    logic [15:0] a;
    logic [31:0] d;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    void'($urandom(32'h7CC9DAB2));
    chk_v("reset vector", 32'hFFFE, 32'(reset_vector_addr));
    // Boundary addresses first, then random ones
    for (i = 0; i < 60; i++) begin
      a = (i < 19) ? corner[i] : 16'($urandom);
      k = mmac_kind_e'((i < 19) ? i % 3 : $urandom_range(2));
      r = exp_region(a, 4, 32);
      acc(k, SRC_CPU, E_SEG, a, W_WORD, $urandom);
      chk_v("region", 32'(r), 32'(u_region));
      chk_b("refused", r == REG_VACANT || (k == K_FETCH && a <= 16'h0FFF), u_refused);
      chk_b("reset pulse", k == K_FETCH && a <= 16'h0FFF, saw_rst);
      if (r == REG_VACANT) chk_b("vacant flag", 1'b1, vacant_access_flag);
    end
    done("decode");
    vacant_clr = 1'b1;
    @(negedge core_clk);
    vacant_clr = 1'b0;
    acc(K_READ, SRC_CPU, E_SEG, 16'h1B00);
    chk_b("flag", 1'b1, vacant_access_flag);
    chk_b("event masked", 1'b0, sys_nmi);
    vacant_ie = 1'b1;
    @(negedge core_clk);
    chk_b("event raised", 1'b1, sys_nmi);
    vacant_clr = 1'b1;
    @(negedge core_clk);
    vacant_clr = 1'b0;
    chk_b("flag cleared", 1'b0, vacant_access_flag);
    done("vacant");
    acc(K_ERASE, SRC_CPU, E_SEG, 16'hA3F0);
    chk_b("segment erase", 1'b1, saw_er && erase_main_seg_en);
    chk_v("segment", 32'h51, 32'(erase_seg));
    acc(K_ERASE, SRC_CPU, E_SEG, 16'hFF80);
    chk_v("vector segment", 32'h7F, 32'(erase_seg));
    acc(K_ERASE, SRC_CPU, E_MAIN_ALL, 16'h0000);
    chk_b("mass erase", 1'b1, saw_er && erase_main_all);
    for (i = 0; i < 4; i++) begin
      acc(K_ERASE, SRC_CPU, E_INFO_SEG, 16'h1800 + 16'(i * 128));
      chk_v("info mask", 32'(1 << i), 32'(erase_info_mask));
    end
    acc(K_ERASE, SRC_CPU, E_ALL, 16'h0000);
    chk_v("all mask", 32'hF, 32'(erase_info_mask));
    chk_b("all main", 1'b1, erase_main_all);
    acc(K_ERASE, SRC_CPU, E_INFO_SEG, 16'h8000);
    chk_b("info erase outside", 1'b1, u_refused);
    acc(K_ERASE, SRC_CPU, E_SEG, 16'h1900);
    chk_b("segment erase outside", 1'b1, u_refused);
    lock_a = 1'b1;
    acc(K_ERASE, SRC_CPU, E_INFO_SEG, 16'h19A0);
    chk_b("locked erase", 1'b1, u_refused && !saw_er);
    acc(K_ERASE, SRC_CPU, E_ALL, 16'h0000);
    chk_v("locked all mask", 32'h7, 32'(erase_info_mask));
    acc(K_WRITE, SRC_CPU, E_SEG, 16'h19C0, W_BYTE);
    chk_b("locked write", 1'b1, u_refused);
    acc(K_WRITE, SRC_CPU, E_SEG, 16'h1880, W_BYTE);
    chk_b("other info write", 1'b0, u_refused);
    lock_a = 1'b0;
    done("erase");
    // Three processor widths, then long writes from both debug ports
    for (i = 0; i < 5; i++) begin
      d = $urandom;
      a = 16'hC000 + 16'(i * 4);
      acc(K_WRITE, mmac_src_e'((i < 3) ? 0 : i - 2), E_SEG, a, (i < 3) ? mmac_width_e'(i) : W_LONG, d);
      chk_b("program pulse", 1'b1, saw_pg);
      chk_v("width", 32'((i < 3) ? i : 1), 32'(prog_width));
      chk_v("program address", 32'(a), 32'(prog_addr));
      if (i == 2) chk_v("long data", d, prog_data);
    end
    done("program");
    u_test_en = 1'b1;
    repeat (6) @(negedge core_clk);
    chk_b("test port on", 1'b1, test_port_mode);
    acc(K_READ, SRC_TWO, E_SEG, 16'h1B00);
    repeat (4) @(negedge core_clk);
    chk_b("two-wire answer", 1'b0, u_tw_bit);
    repeat (24) @(negedge core_clk);
    chk_b("pin released", 1'b1, u_tw_bit);
    u_test_en = 1'b0;
    repeat (6) @(negedge core_clk);
    chk_b("test port off", 1'b0, test_port_mode);
    done("two-wire");
    acc(K_READ, SRC_BOOT, E_SEG, 16'h8000);
    chk_b("boot locked", 1'b1, u_refused);
    u_boot_enter = 1'b1;
    @(negedge core_clk);
    u_boot_enter = 1'b0;
    for (i = 0; i < 400 && u_busy !== 1'b0; i++) @(negedge core_clk);
    repeat (6) @(negedge core_clk);
    chk_b("entry", 1'b1, boot_loader_active);
    acc(K_PASS, SRC_BOOT, E_SEG, 16'h0000, W_LONG, ~PW);
    chk_b("bad password", 1'b1, u_refused);
    acc(K_PASS, SRC_BOOT, E_SEG, 16'h0000, W_LONG, PW);
    chk_b("unlocked", 1'b1, boot_loader_unlocked && !u_refused);
    acc(K_READ, SRC_BOOT, E_SEG, 16'h8000);
    chk_b("boot read", 1'b0, u_refused);
    done("boot");
    give_verdict();
  end
endmodule : tb_memory_map_access_control
